// >>> psc_pkg.sv
package psc_pkg;

    localparam int CLK_KHZ        = 25_000;
    localparam int CLK_NS         = 40;
    localparam int RESET_HOLD_MS  = 100;
    localparam int RESET_HOLD_CYC = RESET_HOLD_MS * CLK_KHZ;
    localparam int WD_STEP_MS     = 100;
    localparam int WD_STEP_CYC    = WD_STEP_MS * CLK_KHZ;
    localparam int TRIM_HZ        = 512;
    localparam int TRIM_HALF_CYC  = (CLK_KHZ * 1000) / (2 * TRIM_HZ);
    localparam int DEBOUNCE_NS    = 640;
    localparam int DEBOUNCE_CYC   = (DEBOUNCE_NS + CLK_NS - 1) / CLK_NS;
    localparam int HOLD_W         = 22;
    localparam int TRIM_W         = 15;
    localparam int DEB_W          = 4;

    // arbitrary bus address for the companion
    localparam logic [6:0] DEV_ID = 7'h5a;

    localparam logic [7:0] REG_FLAGS     = 8'h09;
    localparam logic [7:0] REG_WD        = 8'h0a;
    localparam logic [7:0] REG_CFG       = 8'h0b;
    localparam logic [7:0] REG_EVC       = 8'h0c;
    localparam logic [7:0] REG_EV1_LO    = 8'h0d;
    localparam logic [7:0] REG_EV1_HI    = 8'h0e;
    localparam logic [7:0] REG_EV2_LO    = 8'h0f;
    localparam logic [7:0] REG_EV2_HI    = 8'h10;
    localparam logic [7:0] REG_SID_FIRST = 8'h11;
    localparam logic [7:0] REG_SID_LAST  = 8'h18;

    localparam int FLG_WTR   = 7;
    localparam int FLG_POR   = 6;
    localparam int WD_ARM    = 7;
    localparam int CFG_LOCK  = 7;
    localparam int CFG_TRIP  = 0;
    localparam int EVC_POL1  = 0;
    localparam int EVC_POL2  = 1;
    localparam int EVC_CHAIN = 2;
    localparam int EVC_SNAP  = 3;

    localparam logic [3:0] KICK_CODE = 4'ha;
    localparam logic [4:0] WD_STOP   = 5'h1f;
    localparam logic [7:0] WD_RST    = 8'h00;
    localparam logic [7:0] CFG_RST   = 8'h00;
    localparam logic [3:0] EVC_RST   = 4'h0;

    // synchroniser lanes
    localparam int SY_SCL  = 0;
    localparam int SY_SDA  = 1;
    localparam int SY_RSTP = 2;
    localparam int SY_LOW  = 3;
    localparam int SY_FAIL = 4;
    localparam int SY_EV1  = 5;
    localparam int SY_EV2  = 6;
    localparam logic [6:0] SY_RST = 7'h07;

    typedef enum logic [3:0] {
        PSC_IDLE    = 4'h0,
        PSC_DEV_ID  = 4'h1,
        PSC_ID_ACK  = 4'h2,
        PSC_REG_PTR = 4'h3,
        PSC_PTR_ACK = 4'h4,
        PSC_WR_BYTE = 4'h5,
        PSC_WR_ACK  = 4'h6,
        PSC_RD_BYTE = 4'h7,
        PSC_RD_ACK  = 4'h8
    } psc_i2c_e;

    typedef struct packed {
        logic       en;
        logic [7:0] addr;
        logic [7:0] data;
    } psc_wr_s;

endpackage

// >>> psc_supervisor.sv
`timescale 1ns/10ps
module psc_supervisor #(
    parameter int unsigned HOLD_CYC  = psc_pkg::RESET_HOLD_CYC,
    parameter int unsigned STEP_CYC  = psc_pkg::WD_STEP_CYC,
    parameter int unsigned TRIM_HALF = psc_pkg::TRIM_HALF_CYC
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      sda_out,
    output logic      sda_oe,
    input  wire logic rst_pin_in,
    output logic      rst_pin_out,
    output logic      rst_pin_oe,
    input  wire logic supply_low_in,
    input  wire logic early_fail_in,
    input  wire logic trim_mode_in,
    input  wire logic event_in_1,
    input  wire logic event_in_2,
    output logic      trip_level_select,
    output logic      power_warn_or_trim_out
);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    logic [6:0]                    sy1_q;
    logic [6:0]                    sy2_q;
    logic [6:0]                    prev_q;
    logic                          scl_rise;
    logic                          scl_fall;
    logic                          start_det;
    logic                          stop_det;
    psc_pkg::psc_i2c_e             st_q;
    logic [3:0]                    bits_q;
    logic [7:0]                    shift_q;
    logic [7:0]                    tx_q;
    logic [7:0]                    ptr_q;
    logic                          rw_q;
    logic                          nack_q;
    logic                          sda_oe_q;
    psc_pkg::psc_wr_s              wr;
    logic [7:0]                    rd_data;
    logic [1:0]                    flags_q;
    logic [7:0]                    wd_setup_q;
    logic [7:0]                    cfg_q;
    logic [3:0]                    evc_q;
    logic [7:0]                    sid_q [0:7];
    logic [31:0]                   cnt_q;
    logic [31:0]                   snap_q;
    logic                          kick;
    logic                          wd_run;
    logic                          wd_expire;
    logic [psc_pkg::HOLD_W-1:0]    step_q;
    logic [4:0]                    ticks_q;
    logic [4:0]                    per_q;
    logic [4:0]                    limit;
    logic                          rst_drive_q;
    logic [psc_pkg::HOLD_W-1:0]    hold_q;
    logic [psc_pkg::DEB_W-1:0]     deb_q;
    logic                          man_trig;
    logic [psc_pkg::TRIM_W-1:0]    trim_q;
    logic                          sq_q;
    logic                          pwr_q;
    logic                          ev1;
    logic                          ev2;
    logic                          cnt_wr;

    function automatic logic is_sid(input logic [7:0] a);
        is_sid = (a >= psc_pkg::REG_SID_FIRST) && (a <= psc_pkg::REG_SID_LAST);
    endfunction

    function automatic logic is_cnt(input logic [7:0] a);
        is_cnt = (a >= psc_pkg::REG_EV1_LO) && (a <= psc_pkg::REG_EV2_HI);
    endfunction

    function automatic logic edge_of(input logic now, input logic was, input logic falling);
        edge_of = falling ? (was & ~now) : (now & ~was);
    endfunction

    function automatic logic supply_low_s();
        supply_low_s = sy2_q[psc_pkg::SY_LOW];
    endfunction

    // all pin inputs except trim_mode_in, and the analog indications, pass two flops first
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            sy1_q  <= psc_pkg::SY_RST;
            sy2_q  <= psc_pkg::SY_RST;
            prev_q <= psc_pkg::SY_RST;
        end
        else if (ce)
        begin
            sy1_q  <= {event_in_2, event_in_1, early_fail_in, supply_low_in, rst_pin_in, sda_in, scl_in};
            sy2_q  <= sy1_q;
            prev_q <= sy2_q;
        end

    assign scl_rise  = ce & sy2_q[psc_pkg::SY_SCL] & ~prev_q[psc_pkg::SY_SCL];
    assign scl_fall  = ce & ~sy2_q[psc_pkg::SY_SCL] & prev_q[psc_pkg::SY_SCL];
    assign start_det = sy2_q[psc_pkg::SY_SCL] & prev_q[psc_pkg::SY_SDA] & ~sy2_q[psc_pkg::SY_SDA];
    assign stop_det  = sy2_q[psc_pkg::SY_SCL] & ~prev_q[psc_pkg::SY_SDA] & sy2_q[psc_pkg::SY_SDA];

    // two-wire slave; a driven reset forces it idle so nothing is acknowledged
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            st_q     <= psc_pkg::PSC_IDLE;
            bits_q   <= 4'h0;
            shift_q  <= 8'h00;
            tx_q     <= 8'h00;
            ptr_q    <= 8'h00;
            rw_q     <= 1'b0;
            nack_q   <= 1'b0;
            sda_oe_q <= 1'b0;
        end
        else if (ce)
        begin
            if (rst_drive_q || stop_det)
            begin
                st_q     <= psc_pkg::PSC_IDLE;
                sda_oe_q <= 1'b0;
            end
            else if (start_det)
            begin
                st_q     <= psc_pkg::PSC_DEV_ID;
                bits_q   <= 4'h0;
                sda_oe_q <= 1'b0;
            end
            else if (scl_rise)
            begin
                case (st_q)
                    psc_pkg::PSC_DEV_ID, psc_pkg::PSC_REG_PTR, psc_pkg::PSC_WR_BYTE:
                    begin
                        shift_q <= {shift_q[6:0], sy2_q[psc_pkg::SY_SDA]};
                        bits_q  <= bits_q + 4'h1;
                    end
                    psc_pkg::PSC_RD_BYTE:
                        bits_q <= bits_q + 4'h1;
                    psc_pkg::PSC_RD_ACK:
                        nack_q <= sy2_q[psc_pkg::SY_SDA];
                    default:
                        ;
                endcase
            end
            else if (scl_fall)
            begin
                case (st_q)
                    psc_pkg::PSC_DEV_ID:
                        if (bits_q == 4'h8)
                        begin
                            if (shift_q[7:1] == psc_pkg::DEV_ID)
                            begin
                                sda_oe_q <= 1'b1;
                                rw_q     <= shift_q[0];
                                st_q     <= psc_pkg::PSC_ID_ACK;
                            end
                            else
                                st_q <= psc_pkg::PSC_IDLE;
                        end
                    psc_pkg::PSC_REG_PTR:
                        if (bits_q == 4'h8)
                        begin
                            ptr_q    <= shift_q;
                            sda_oe_q <= 1'b1;
                            st_q     <= psc_pkg::PSC_PTR_ACK;
                        end
                    psc_pkg::PSC_WR_BYTE:
                        if (bits_q == 4'h8)
                        begin
                            ptr_q    <= ptr_q + 8'h01;
                            sda_oe_q <= 1'b1;
                            st_q     <= psc_pkg::PSC_WR_ACK;
                        end
                    psc_pkg::PSC_ID_ACK, psc_pkg::PSC_RD_ACK:
                    begin
                        bits_q <= 4'h0;
                        if ((st_q == psc_pkg::PSC_RD_ACK) && nack_q)
                        begin
                            sda_oe_q <= 1'b0;
                            st_q     <= psc_pkg::PSC_IDLE;
                        end
                        else if ((st_q == psc_pkg::PSC_ID_ACK) && !rw_q)
                        begin
                            sda_oe_q <= 1'b0;
                            st_q     <= psc_pkg::PSC_REG_PTR;
                        end
                        else
                        begin
                            tx_q     <= rd_data;
                            sda_oe_q <= ~rd_data[7];
                            st_q     <= psc_pkg::PSC_RD_BYTE;
                        end
                    end
                    psc_pkg::PSC_PTR_ACK, psc_pkg::PSC_WR_ACK:
                    begin
                        sda_oe_q <= 1'b0;
                        bits_q   <= 4'h0;
                        st_q     <= psc_pkg::PSC_WR_BYTE;
                    end
                    psc_pkg::PSC_RD_BYTE:
                        if (bits_q == 4'h8)
                        begin
                            sda_oe_q <= 1'b0;
                            ptr_q    <= ptr_q + 8'h01;
                            st_q     <= psc_pkg::PSC_RD_ACK;
                        end
                        else
                        begin
                            tx_q     <= {tx_q[6:0], 1'b0};
                            sda_oe_q <= ~tx_q[6];
                        end
                    default:
                        ;
                endcase
            end
        end

    assign sda_oe  = sda_oe_q;
    assign sda_out = 1'b0;

    always_comb
    begin
        wr.en   = scl_fall && (st_q == psc_pkg::PSC_WR_BYTE) && (bits_q == 4'h8)
                  && !rst_drive_q && !stop_det && !start_det;
        wr.addr = ptr_q;
        wr.data = shift_q;
    end

    // counters always read from the snapshot so a multi-byte read is coherent
    always_comb
    begin
        if (ptr_q == psc_pkg::REG_FLAGS)
            rd_data = {flags_q, 6'h00};
        else if (ptr_q == psc_pkg::REG_WD)
            rd_data = wd_setup_q;
        else if (ptr_q == psc_pkg::REG_CFG)
            rd_data = cfg_q;
        else if (ptr_q == psc_pkg::REG_EVC)
            rd_data = {4'h0, evc_q};
        else if (is_cnt(ptr_q))
            rd_data = snap_q[8 * (ptr_q - psc_pkg::REG_EV1_LO) +: 8];
        else if (is_sid(ptr_q))
            rd_data = sid_q[3'(ptr_q - psc_pkg::REG_SID_FIRST)];
        else
            rd_data = 8'h00;
    end

    assign kick = wr.en && (wr.addr == psc_pkg::REG_FLAGS) && (wr.data[3:0] == psc_pkg::KICK_CODE);

    // sticky flags: hardware set beats a software clear in the same cycle
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            flags_q <= 2'b00;
        else if (ce)
        begin
            if (supply_low_s())
                flags_q[0] <= 1'b1;
            else if (wr.en && (wr.addr == psc_pkg::REG_FLAGS) && !wr.data[psc_pkg::FLG_POR])
                flags_q[0] <= 1'b0;
            if (wd_expire)
                flags_q[1] <= 1'b1;
            else if (wr.en && (wr.addr == psc_pkg::REG_FLAGS) && !wr.data[psc_pkg::FLG_WTR])
                flags_q[1] <= 1'b0;
        end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            wd_setup_q <= psc_pkg::WD_RST;
            cfg_q      <= psc_pkg::CFG_RST;
            evc_q      <= psc_pkg::EVC_RST;
            for (int i = 0; i < 8; i++)
                sid_q[i] <= 8'h00;
        end
        else if (ce && wr.en)
        begin
            if (wr.addr == psc_pkg::REG_WD)
                wd_setup_q <= {wr.data[7], 2'b00, wr.data[4:0]};
            else if (wr.addr == psc_pkg::REG_CFG)
                cfg_q <= {cfg_q[psc_pkg::CFG_LOCK] | wr.data[7], wr.data[6:0]};
            else if (wr.addr == psc_pkg::REG_EVC)
                evc_q <= wr.data[3:0];
            else if (is_sid(wr.addr) && !cfg_q[psc_pkg::CFG_LOCK])
                sid_q[3'(wr.addr - psc_pkg::REG_SID_FIRST)] <= wr.data;
        end

    assign trip_level_select = cfg_q[psc_pkg::CFG_TRIP];

    // watchdog: held cleared when stopped, supply low or reset driven
    assign wd_run    = !supply_low_s() && !rst_drive_q && (wd_setup_q[4:0] != psc_pkg::WD_STOP);
    assign limit     = (per_q == 5'h00) ? 5'h01 : per_q;
    assign wd_expire = ce && wd_run && !kick && (step_q == psc_pkg::HOLD_W'(STEP_CYC - 1))
                       && ({1'b0, ticks_q} + 6'h01 >= {1'b0, limit});

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            step_q  <= '0;
            ticks_q <= 5'h00;
            per_q   <= 5'h00;
        end
        else if (ce)
        begin
            if (!wd_run || kick)
            begin
                step_q  <= '0;
                ticks_q <= 5'h00;
                per_q   <= wd_setup_q[4:0];
            end
            else if (step_q == psc_pkg::HOLD_W'(STEP_CYC - 1))
            begin
                step_q  <= '0;
                ticks_q <= wd_expire ? 5'h00 : ticks_q + 5'h01;
            end
            else
                step_q <= step_q + 1'b1;
        end

    // own drive reads back low, so the debounce only counts while released
    assign man_trig = ce && !rst_drive_q && !sy2_q[psc_pkg::SY_RSTP]
                      && (deb_q == psc_pkg::DEB_W'(psc_pkg::DEBOUNCE_CYC - 1));

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            deb_q <= '0;
        else if (ce)
        begin
            if (rst_drive_q || sy2_q[psc_pkg::SY_RSTP])
                deb_q <= '0;
            else if (deb_q != psc_pkg::DEB_W'(psc_pkg::DEBOUNCE_CYC - 1))
                deb_q <= deb_q + 1'b1;
        end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            rst_drive_q <= 1'b0;
            hold_q      <= '0;
        end
        else if (ce)
        begin
            if (supply_low_s() || (wd_expire && wd_setup_q[psc_pkg::WD_ARM]) || man_trig)
            begin
                rst_drive_q <= 1'b1;
                hold_q      <= psc_pkg::HOLD_W'(HOLD_CYC - 1);
            end
            else if (rst_drive_q)
            begin
                if (hold_q == '0)
                    rst_drive_q <= 1'b0;
                else
                    hold_q <= hold_q - 1'b1;
            end
        end

    assign rst_pin_oe  = rst_drive_q;
    assign rst_pin_out = 1'b0;

    // the square wave free-runs so entering trim mode needs no restart
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
        begin
            trim_q <= '0;
            sq_q   <= 1'b0;
            pwr_q  <= 1'b1;
        end
        else if (ce)
        begin
            if (trim_q == psc_pkg::TRIM_W'(TRIM_HALF - 1))
            begin
                trim_q <= '0;
                sq_q   <= ~sq_q;
            end
            else
                trim_q <= trim_q + 1'b1;
            pwr_q <= trim_mode_in ? sq_q : ~sy2_q[psc_pkg::SY_FAIL];
        end

    assign power_warn_or_trim_out = pwr_q;

    assign ev1    = edge_of(sy2_q[psc_pkg::SY_EV1], prev_q[psc_pkg::SY_EV1], evc_q[psc_pkg::EVC_POL1]);
    assign ev2    = edge_of(sy2_q[psc_pkg::SY_EV2], prev_q[psc_pkg::SY_EV2], evc_q[psc_pkg::EVC_POL2]);
    assign cnt_wr = wr.en && is_cnt(wr.addr);

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            cnt_q <= 32'h0000_0000;
        else if (ce)
        begin
            if (cnt_wr)
                cnt_q[8 * (wr.addr - psc_pkg::REG_EV1_LO) +: 8] <= wr.data;
            else if (evc_q[psc_pkg::EVC_CHAIN])
                cnt_q <= cnt_q + {31'h0, ev1};
            else
            begin
                cnt_q[15:0]  <= cnt_q[15:0] + {15'h0, ev1};
                cnt_q[31:16] <= cnt_q[31:16] + {15'h0, ev2};
            end
        end

    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            snap_q <= 32'h0000_0000;
        else if (ce && wr.en && (wr.addr == psc_pkg::REG_EVC) && wr.data[psc_pkg::EVC_SNAP])
            snap_q <= cnt_q;

    // properties read the flop bit itself: state read inside a function body is not sampled
    property p_low_hold;
        ce && sy2_q[psc_pkg::SY_LOW] |=> rst_drive_q && (hold_q == psc_pkg::HOLD_W'(HOLD_CYC - 1));
    endproperty
    a_low_hold: assert property (p_low_hold) else $error("supply low did not load reset hold");

    property p_hold_on;
        rst_drive_q && (hold_q != '0) |=> rst_drive_q;
    endproperty
    a_hold_on: assert property (p_hold_on) else $error("reset released before hold ran out");

    property p_bus_quiet;
        ce && rst_drive_q |=> !sda_oe && (st_q == psc_pkg::PSC_IDLE);
    endproperty
    a_bus_quiet: assert property (p_bus_quiet) else $error("bus answered during reset");

    property p_trip;
        ce && wr.en && (wr.addr == psc_pkg::REG_CFG) |=> trip_level_select == $past(wr.data[0]);
    endproperty
    a_trip: assert property (p_trip) else $error("trip select not taken from config bit 0");

    property p_stop;
        wd_setup_q[4:0] == psc_pkg::WD_STOP |-> !wd_expire && (step_q == '0 || !$stable(wd_setup_q));
    endproperty
    a_stop: assert property (p_stop) else $error("watchdog ran with stop code");

    property p_unarmed;
        wd_expire && !wd_setup_q[psc_pkg::WD_ARM] && !man_trig |=> !rst_drive_q && flags_q[1];
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("unarmed expiry drove reset or missed flag");

    property p_kick;
        ce && kick |=> (step_q == '0) && (ticks_q == 5'h00) && (per_q == $past(wd_setup_q[4:0]));
    endproperty
    a_kick: assert property (p_kick) else $error("kick did not restart the watchdog");

    property p_por;
        ce && sy2_q[psc_pkg::SY_LOW] |=> flags_q[0] ##1 (flags_q[0] || !$past(sy2_q[psc_pkg::SY_LOW]));
    endproperty
    a_por: assert property (p_por) else $error("supply flag not set");

    property p_warn;
        ce && !trim_mode_in |=> power_warn_or_trim_out == !$past(sy2_q[psc_pkg::SY_FAIL]);
    endproperty
    a_warn: assert property (p_warn) else $error("warning output does not follow comparator");

    property p_lock;
        cfg_q[psc_pkg::CFG_LOCK] |=> cfg_q[psc_pkg::CFG_LOCK];
    endproperty
    a_lock: assert property (p_lock) else $error("serial id lock was cleared");

endmodule

// >>> psc_host.sv
`timescale 1ns/10ps
module psc_host (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl = 1'b1,
    output logic      sda_low = 1'b0
);
    logic ack;
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // scl is still between frames; within a data bit sda only moves while scl is low
    task automatic bit_io(input logic b, output logic r);
        sda_low <= ~b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda;
        tick(2);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic xbyte(input logic [7:0] x, input logic nak, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
            bit_io(x[i], r[i]);
        bit_io(nak, ack);
    endtask
    task automatic start();
        sda_low <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b1;
        tick(4);
        scl <= 1'b0;
        tick(2);
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_low <= 1'b0;
        tick(4);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input int n);
        logic [7:0] r;
        start();
        xbyte({psc_pkg::DEV_ID, 1'b0}, 1'b1, r);
        xbyte(a, 1'b1, r);
        for (int i = 0; i < n; i++)
            xbyte(d[8*i +: 8], 1'b1, r);
        stop();
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        wr(a, 32'h0, 0);
        start();
        xbyte({psc_pkg::DEV_ID, 1'b1}, 1'b1, d);
        xbyte(8'hff, 1'b1, d);
        stop();
    endtask
endmodule

// >>> processor_supervisor_companion_test.sv
`timescale 1ns/10ps
module processor_supervisor_companion_test;
    logic       clk = 1'b0, rst_b = 1'b0, sup = 1'b0, fail = 1'b0, trim = 1'b0, ce = 1'b1;
    logic       ev1 = 1'b0, ev2 = 1'b0, man = 1'b0, b;
    logic       scl, sda_low, sda_oe, rst_oe, warn, tls;
    logic [7:0] v;
    int         n_mismatch = 0;
    int         tests_run = 0;
    wire        sda = ~(sda_low | sda_oe);
    wire        rst_pin = ~(rst_oe | man);
    always #20 clk = ~clk;
    psc_supervisor #(.HOLD_CYC(40), .STEP_CYC(1000), .TRIM_HALF(8)) i_dut (.clk(clk), .rst_b(rst_b),
        .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe(sda_oe), .rst_pin_in(rst_pin),
        .rst_pin_out(), .rst_pin_oe(rst_oe), .supply_low_in(sup), .early_fail_in(fail), .trim_mode_in(trim),
        .event_in_1(ev1), .event_in_2(ev2), .trip_level_select(tls), .power_warn_or_trim_out(warn));
    psc_host i_host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk({7'h0, g}, {7'h0, e});
    endtask
    task automatic w(input int n);
        i_host.tick(n);
    endtask
    task automatic pulse(input logic two, input int n);
        repeat (n)
        begin
            {ev2, ev1} <= two ? 2'b10 : 2'b01;
            w(4);
            {ev2, ev1} <= 2'b00;
            w(4);
        end
    endtask
    task automatic t_sid();
        i_host.wr(8'h0b, 32'h02, 1);
        chk1(i_host.ack, 1'b0);
        chk1(tls, 1'b0);
        i_host.wr(8'h11, 32'h3c, 1);
        i_host.wr(8'h0b, 32'h81, 1);
        chk1(tls, 1'b1);
        i_host.wr(8'h11, 32'hc3, 1);
        i_host.wr(8'h0b, 32'h00, 1);
        i_host.rd(8'h11, v);
        chk(v, 8'h3c);
        i_host.rd(8'h0b, v);
        chk(v & 8'h80, 8'h80);
    endtask
    task automatic t_evt();
        i_host.wr(8'h0c, 32'h00, 1);
        i_host.wr(8'h0d, 32'h0000_fffe, 4);
        pulse(1'b0, 3);
        pulse(1'b1, 1);
        i_host.wr(8'h0c, 32'h08, 1);
        pulse(1'b1, 2);
        i_host.rd(8'h0d, v);
        chk(v, 8'h01);
        i_host.rd(8'h0f, v);
        chk(v, 8'h01);
        i_host.wr(8'h0c, 32'h04, 1);
        i_host.wr(8'h0d, 32'h0000_ffff, 4);
        pulse(1'b0, 1);
        pulse(1'b1, 1);
        i_host.wr(8'h0c, 32'h0c, 1);
        i_host.rd(8'h0f, v);
        chk(v, 8'h01);
        i_host.wr(8'h0c, 32'h01, 1);
        i_host.wr(8'h0d, 32'h0, 2);
        ev1 <= 1'b1;
        i_host.wr(8'h0c, 32'h09, 1);
        i_host.rd(8'h0d, v);
        chk(v, 8'h00);
        ev1 <= 1'b0;
        i_host.wr(8'h0c, 32'h09, 1);
        i_host.rd(8'h0d, v);
        chk(v, 8'h01);
    endtask
    task automatic t_warn();
        fail <= 1'b1;
        w(5);
        chk1(warn, 1'b0);
        trim <= 1'b1;
        w(4);
        b = warn;
        w(8);
        chk1(warn ^ b, 1'b1);
        trim <= 1'b0;
        fail <= 1'b0;
        w(5);
        chk1(warn, 1'b1);
    endtask
    task automatic t_man();
        man <= 1'b1;
        w(5);
        man <= 1'b0;
        w(30);
        chk1(rst_oe, 1'b0);
        man <= 1'b1;
        w(24);
        man <= 1'b0;
        w(30);
        chk1(rst_oe, 1'b1);
        w(20);
        chk1(rst_oe, 1'b0);
    endtask
    task automatic t_sup();
        i_host.wr(8'h09, 32'h0a, 1);
        sup <= 1'b1;
        w(5);
        chk1(rst_oe, 1'b1);
        i_host.wr(8'h11, 32'h55, 1);
        chk1(i_host.ack, 1'b1);
        sup <= 1'b0;
        w(30);
        chk1(rst_oe, 1'b1);
        w(20);
        chk1(rst_oe, 1'b0);
        i_host.rd(8'h09, v);
        chk(v & 8'hc0, 8'h40);
    endtask
    task automatic t_wd();
        i_host.wr(8'h0a, 32'h01, 1);
        i_host.wr(8'h09, 32'h0a, 1);
        w(1100);
        chk1(rst_oe, 1'b0);
        i_host.rd(8'h09, v);
        chk(v & 8'h80, 8'h80);
        i_host.wr(8'h09, 32'h0a, 1);
        i_host.wr(8'h0a, 32'h81, 1);
        i_host.wr(8'h09, 32'h3a, 1);
        w(670);
        i_host.wr(8'h09, 32'h05, 1);
        chk1(rst_oe, 1'b0);
        for (int i = 0; i < 200 && rst_oe !== 1'b1; i++)
            w(1);
        chk1(rst_oe, 1'b1);
        w(60);
        i_host.wr(8'h0a, 32'h9f, 1);
        i_host.wr(8'h09, 32'h0a, 1);
        w(2100);
        chk1(rst_oe, 1'b0);
    endtask
    task automatic t_ce();
        ce <= 1'b0;
        sup <= 1'b1;
        w(10);
        chk1(rst_oe, 1'b0);
        ce <= 1'b1;
        w(5);
        chk1(rst_oe, 1'b1);
        sup <= 1'b0;
        w(60);
        chk1(rst_oe, 1'b0);
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        #2_000_000;
        n_mismatch++;
        give_verdict();
    end
    initial
    begin
        w(5);
        rst_b <= 1'b1;
        w(3);
        t_sid();
        t_evt();
        t_warn();
        t_man();
        t_sup();
        t_wd();
        t_ce();
        give_verdict();
    end
endmodule
